// ===== hdl/backlight_fault_direct_ctl.sv
// Fault flags, protection shutdowns and output override register bank
//
// Implementation choice: the Wishbone register port.

`timescale 1ns/1ps
`default_nettype none

module backlight_fault_direct_ctl
  import backlight_fault_pkg::*;
#(
  parameter int unsigned OCP_DELAY_CYCLES = OCP_CYCLES,
  parameter logic        PANEL_ID         = 1'b0,
  // Arbitrary identification values
  parameter logic [3:0]  MAKER_CODE       = 4'h5,
  parameter logic [2:0]  REVISION_CODE    = 3'h1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        enable_pin_i,
  input  wire logic [5:0]  chan_fault_i,
  input  wire logic        overcurrent_i,
  input  wire logic        boost_low_i,
  input  wire logic        over_temp_i,
  input  wire logic        temp_recovered_i,
  input  wire logic [2:0]  uv_sel_i,
  input  wire logic [15:0] supply_input_mv_i,
  input  wire logic [5:0]  led_pwm_i,
  output logic      [5:0]  led_out_o,
  output logic             boost_en_o,
  output logic             led_en_o,
  output logic             fault_pin_o,
  output logic             fault_pin_oe_n_o,
  output logic             irq_o
);

  //////////////////////////////////////////////////////////////////////////

  state_t q;
  state_t d;

  function automatic logic [2:0] count_faults(input logic [5:0] f);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++) begin
      n = n + {2'b00, f[i]};
    end
    return n;
  endfunction

  //////////////////////////////////////////////////////////////////////////

  // Pins and bus decode
  pins_t       pins_raw;
  pins_t       pins;
  logic        bus_req;
  logic        bus_wr;
  logic        bus_rd;
  logic [5:0]  idx;
  logic        fault_read;
  logic        st_read;
  logic        clear_all;

  // Fault conditions and flags
  logic [2:0]  nfaults;
  logic [7:0]  cond;
  logic        ocp_cond;
  logic        ocp_done;
  logic        undervolt;
  logic        ocp_trip;
  logic [7:0]  flags_next;
  logic [7:0]  new_events;
  logic [7:0]  id_value;

  // Protection and output gating
  logic [23:0] ocp_cnt_next;
  logic        boost_off_next;
  logic        thermal_next;
  logic        cause_boost;
  logic        cause_thermal;
  logic        cause_uv;
  logic        outputs_on;
  logic [5:0]  led_next;
  logic        any_flag;

  // Register next values and read data
  logic [5:0]  override_next;
  logic [7:0]  irq_mask_next;
  logic [7:0]  irq_st_next;
  logic [31:0] rd_word;

  always_comb begin
    pins_raw.enable         = enable_pin_i;
    pins_raw.chan_fault     = chan_fault_i;
    pins_raw.overcurrent    = overcurrent_i;
    pins_raw.boost_low      = boost_low_i;
    pins_raw.over_temp      = over_temp_i;
    pins_raw.temp_recovered = temp_recovered_i;
    pins_raw.uv_sel         = uv_sel_i;
  end

  assign pins     = q.sync2;
  assign id_value = {PANEL_ID, MAKER_CODE, REVISION_CODE};

  //////////////////////////////////////////////////////////////////////////
  // Bus decode: one access per ack, answered the cycle after the request

  assign bus_req    = wb_cyc_i & wb_stb_i & ~q.ack;
  assign bus_wr     = bus_req & wb_we_i & wb_sel_i[0];
  assign bus_rd     = bus_req & ~wb_we_i;
  assign idx        = wb_adr_i[7:2];
  assign fault_read = bus_rd & (idx == IDX_FAULT_STATUS);
  assign st_read    = bus_rd & (idx == IDX_IRQ_STATUS);
  assign clear_all  = fault_read | ~pins.enable;

  //////////////////////////////////////////////////////////////////////////
  // Fault conditions

  assign nfaults   = count_faults(pins.chan_fault);
  assign ocp_cond  = pins.overcurrent & pins.boost_low;
  assign undervolt = supply_input_mv_i < UV_THRESH_MV[pins.uv_sel];
  assign ocp_done  = {8'h00, q.ocp_cnt} >= OCP_DELAY_CYCLES;
  assign ocp_trip  = ocp_cond & ocp_done;

  always_comb begin
    cond                     = 8'h00;
    cond[BIT_MULTI_CHANNEL]  = nfaults >= 3'h2;
    cond[BIT_SINGLE_CHANNEL] = nfaults == 3'h1;
    cond[BIT_ANY_LED]        = |pins.chan_fault;
    cond[BIT_OVERCURRENT]    = ocp_trip;
    cond[BIT_THERMAL]        = pins.over_temp;
    cond[BIT_UNDERVOLTAGE]   = undervolt;
  end

  // Flags are sticky and a new cause beats a clear in the same cycle
  always_comb begin
    if (clear_all) begin
      flags_next = cond;
    end else begin
      flags_next = q.flags | cond;
    end
  end

  assign new_events = cond & ~q.flags;

  //////////////////////////////////////////////////////////////////////////
  // Protection timers and holds

  // Overcurrent qualification timer, restarted whenever the cause drops
  always_comb begin
    ocp_cnt_next = q.ocp_cnt;
    if (!ocp_cond || !pins.enable) begin
      ocp_cnt_next = RST_OCP_CNT;
    end else if (!ocp_done) begin
      ocp_cnt_next = q.ocp_cnt + 24'h000001;
    end
  end

  // Boost stays off after an overcurrent trip until the flag is cleared
  always_comb begin
    boost_off_next = q.boost_off;
    if (ocp_trip) begin
      boost_off_next = 1'b1;
    end else if (clear_all) begin
      boost_off_next = 1'b0;
    end
  end

  // Thermal hold lasts until the die is back at the recovery point
  always_comb begin
    thermal_next = q.thermal_hold;
    if (pins.over_temp) begin
      thermal_next = 1'b1;
    end else if (pins.temp_recovered) begin
      thermal_next = 1'b0;
    end
  end

  // Any one cause keeps the converter and every LED output off
  assign cause_boost   = boost_off_next;
  assign cause_thermal = thermal_next;
  assign cause_uv      = undervolt;
  assign outputs_on    = pins.enable & ~cause_boost & ~cause_thermal &
                         ~cause_uv;

  // Each LED output follows its override bit, else the PWM level
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (q.override[i]) begin
        led_next[i] = outputs_on;
      end else begin
        led_next[i] = outputs_on & led_pwm_i[i];
      end
    end
  end

  // Open-drain fault pin: pulled low while any flag is set
  assign any_flag = |flags_next;

  //////////////////////////////////////////////////////////////////////////
  // Register writes, interrupt status and read data

  // Writes to the fault, identification and status words fall through
  always_comb begin
    override_next = q.override;
    irq_mask_next = q.irq_mask;
    if (bus_wr) begin
      case (idx)
        IDX_OVERRIDE: begin
          override_next = wb_dat_i[5:0];
        end
        IDX_IRQ_MASK: begin
          irq_mask_next = wb_dat_i[7:0];
        end
        default: begin
          override_next = q.override;
        end
      endcase
    end
  end

  // Interrupt status: set by each newly raised flag, cleared by read
  always_comb begin
    if (st_read) begin
      irq_st_next = new_events;
    end else begin
      irq_st_next = q.irq_st | new_events;
    end
  end

  // Read data: unmapped words read as zero
  always_comb begin
    rd_word = 32'h00000000;
    if (bus_rd) begin
      case (idx)
        IDX_FAULT_STATUS: begin
          rd_word = {24'h000000, q.flags};
        end
        IDX_DEVICE_ID: begin
          rd_word = {24'h000000, id_value};
        end
        IDX_OVERRIDE: begin
          rd_word = {26'h0, q.override};
        end
        IDX_IRQ_MASK: begin
          rd_word = {24'h000000, q.irq_mask};
        end
        IDX_IRQ_STATUS: begin
          rd_word = {24'h000000, q.irq_st};
        end
        default: begin
          rd_word = 32'h00000000;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State update

  always_comb begin
    d = q;

    // Input synchronisers
    d.sync1 = pins_raw;
    d.sync2 = q.sync1;

    // Flags change only through conditions and clears, never writes
    d.flags      = flags_next;
    d.fault_oe_n = ~any_flag;

    // Protection state
    d.ocp_cnt      = ocp_cnt_next;
    d.boost_off    = boost_off_next;
    d.thermal_hold = thermal_next;

    // Output gating
    d.boost_en = outputs_on;
    d.led_en   = outputs_on;
    d.led_out  = led_next;

    // Registers, interrupt and bus answer
    d.override = override_next;
    d.irq_mask = irq_mask_next;
    d.irq_st   = irq_st_next;
    d.irq      = |(irq_st_next & irq_mask_next);
    d.ack      = bus_req;
    d.rdata    = rd_word;
  end

  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.sync1        <= '0;
      q.sync2        <= '0;
      q.flags        <= RST_FAULT;
      q.ocp_cnt      <= RST_OCP_CNT;
      q.boost_off    <= 1'b0;
      q.thermal_hold <= 1'b0;
      q.override     <= RST_OVERRIDE;
      q.irq_mask     <= RST_IRQ_MASK;
      q.irq_st       <= RST_IRQ_ST;
      q.ack          <= 1'b0;
      q.rdata        <= 32'h00000000;
      q.irq          <= 1'b0;
      q.fault_oe_n   <= 1'b1;
      q.led_out      <= 6'h00;
      q.boost_en     <= 1'b0;
      q.led_en       <= 1'b0;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  assign wb_dat_o         = q.rdata;
  assign wb_ack_o         = q.ack;
  assign led_out_o        = q.led_out;
  assign boost_en_o       = q.boost_en;
  assign led_en_o         = q.led_en;
  assign fault_pin_o      = 1'b0;
  assign fault_pin_oe_n_o = q.fault_oe_n;
  assign irq_o            = q.irq;

endmodule

`default_nettype wire

// ===== hdl/backlight_fault_pkg.sv
// Constants and carrier types for the backlight fault and override bank
package backlight_fault_pkg;

  // Word index of each register; byte address is four times the index
  localparam logic [5:0] IDX_FAULT_STATUS  = 6'h02;
  localparam logic [5:0] IDX_DEVICE_ID     = 6'h03;
  localparam logic [5:0] IDX_OVERRIDE      = 6'h04;
  localparam logic [5:0] IDX_IRQ_MASK      = 6'h08;
  localparam logic [5:0] IDX_IRQ_STATUS    = 6'h09;

  // Fault flag positions
  localparam int BIT_MULTI_CHANNEL = 5;
  localparam int BIT_SINGLE_CHANNEL = 4;
  localparam int BIT_ANY_LED       = 3;
  localparam int BIT_OVERCURRENT   = 2;
  localparam int BIT_THERMAL       = 1;
  localparam int BIT_UNDERVOLTAGE  = 0;

  // Values after reset
  localparam logic [7:0]  RST_FAULT     = 8'h00;
  localparam logic [5:0]  RST_OVERRIDE  = 6'h00;
  localparam logic [7:0]  RST_IRQ_MASK  = 8'h00;
  localparam logic [7:0]  RST_IRQ_ST    = 8'h00;
  localparam logic [23:0] RST_OCP_CNT   = 24'h000000;

  // Overcurrent qualification time
  localparam int CLK_FREQ_KHZ  = 100000;
  localparam int OCP_TIME_MS   = 50;
  localparam int OCP_CYCLES    = OCP_TIME_MS * CLK_FREQ_KHZ;

  // Undervoltage thresholds in millivolts, picked by nonvolatile bits
  localparam logic [15:0] UV_THRESH_MV [8] = '{
    16'h0bb8, 16'h0fa0, 16'h1388, 16'h1770,
    16'h1b58, 16'h1f40, 16'h2328, 16'h2328
  };

  // Pin inputs, synchronised as one group
  typedef struct packed {
    logic       enable;
    logic [5:0] chan_fault;
    logic       overcurrent;
    logic       boost_low;
    logic       over_temp;
    logic       temp_recovered;
    logic [2:0] uv_sel;
  } pins_t;

  typedef struct packed {
    pins_t        sync1;
    pins_t        sync2;
    logic [7:0]   flags;
    logic [23:0]  ocp_cnt;
    logic         boost_off;
    logic         thermal_hold;
    logic [5:0]   override;
    logic [7:0]   irq_mask;
    logic [7:0]   irq_st;
    logic         ack;
    logic [31:0]  rdata;
    logic         irq;
    logic         fault_oe_n;
    logic [5:0]   led_out;
    logic         boost_en;
    logic         led_en;
  } state_t;

endpackage

// ===== verif/backlight_fault_direct_ctl_monitor.sv
// Concurrent checks on the backlight fault bank ports
`timescale 1ns/1ps
`default_nettype none
module backlight_fault_direct_ctl_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        enable_pin_i,
  input wire logic [5:0]  led_pwm_i,
  input wire logic [5:0]  led_out_o,
  input wire logic        boost_en_o,
  input wire logic        led_en_o,
  input wire logic        fault_pin_o,
  input wire logic        fault_pin_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_fault_read;
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h08;
  endsequence
  sequence s_en_low;
    !enable_pin_i [*4];
  endsequence
  property p_ack_once; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack missing");
  property p_ack_drop; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack too long");
  property p_pin_level; fault_pin_o == 1'b0; endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("fault pin drives high");
  property p_pin_oe; s_fault_read ##0 (wb_dat_o[7:0] != 8'h00)
    |-> !$past(fault_pin_oe_n_o); endproperty
  a_pin_oe: assert property (p_pin_oe)
    else $error("fault pin released with flags set");
  property p_top_zero; s_fault_read |-> wb_dat_o[31:6] == 26'h0;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("stray flag bits");
  property p_agg; s_fault_read ##0 (wb_dat_o[5] || wb_dat_o[4])
    |-> wb_dat_o[3]; endproperty
  a_agg: assert property (p_agg)
    else $error("aggregate flag low");
  property p_en_pair; boost_en_o == led_en_o; endproperty
  a_en_pair: assert property (p_en_pair)
    else $error("enables differ");
  property p_en_low; s_en_low |-> !boost_en_o && !led_en_o; endproperty
  a_en_low: assert property (p_en_low)
    else $error("on while disabled");
  property p_led_off; !led_en_o |-> led_out_o == 6'h00; endproperty
  a_led_off: assert property (p_led_off)
    else $error("led on when off");
  property p_pwm_pass;
    led_en_o |-> (led_out_o & $past(led_pwm_i)) == $past(led_pwm_i);
  endproperty
  a_pwm_pass: assert property (p_pwm_pass)
    else $error("pwm lost");
endmodule
bind backlight_fault_direct_ctl backlight_fault_direct_ctl_monitor u_mon (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .enable_pin_i, .led_pwm_i, .led_out_o, .boost_en_o, .led_en_o,
  .fault_pin_o, .fault_pin_oe_n_o);
`default_nettype wire

// ===== verif/test_backlight_fault_direct_ctl.sv
// Self-checking bench for the backlight fault bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("Error %0t: got %h expected %h", $time, g, e); \
  end \
end
module test_backlight_fault_direct_ctl;
  typedef struct packed { logic [5:0] chan; logic [7:0] flags; } row_t;
  // Arbitrary identification values
  localparam logic [7:0] ID_EXP = {1'b1, 4'ha, 3'h2};
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic enable_pin_i, overcurrent_i, boost_low_i, over_temp_i;
  logic temp_recovered_i, boost_en_o, led_en_o, fault_pin_o;
  logic fault_pin_oe_n_o, irq_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, junk;
  logic [5:0]  chan_fault_i, led_pwm_i, led_out_o;
  logic [2:0]  uv_sel_i;
  logic [15:0] supply_input_mv_i;
  int          err_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  row_t        rows [4] = '{'{6'h00, 8'h00}, '{6'h01, 8'h18},
                            '{6'h24, 8'h28}, '{6'h3f, 8'h28}};
  backlight_fault_direct_ctl #(.OCP_DELAY_CYCLES(20), .PANEL_ID(1'b1),
    .MAKER_CODE(4'ha), .REVISION_CODE(3'h2)) DUT (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .enable_pin_i, .chan_fault_i, .overcurrent_i,
    .boost_low_i, .over_temp_i, .temp_recovered_i, .uv_sel_i,
    .supply_input_mv_i, .led_pwm_i, .led_out_o, .boost_en_o, .led_en_o,
    .fault_pin_o, .fault_pin_oe_n_o, .irq_o);
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
                    output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    wb(1'b0, a, 8'h00, r);
    `CHK(r, {24'h000000, e})
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, overcurrent_i, boost_low_i} = '0;
    {over_temp_i, temp_recovered_i, chan_fault_i, led_pwm_i} = '0;
    {wb_adr_i, wb_dat_i} = '0;
    {rst_i, enable_pin_i, wb_sel_i, uv_sel_i} = {2'h3, 4'hf, 3'h2};
    supply_input_mv_i = 16'hffff;
    tick(20);
    rst_i <= 1'b0;
    tick(2);
    `CHK({wb_ack_o, fault_pin_oe_n_o, irq_o}, 3'h2)
    foreach (rows[i]) begin
      chan_fault_i <= rows[i].chan;
      tick(6);
      chan_fault_i <= 6'h00;
      tick(4);
      `CHK(fault_pin_oe_n_o, rows[i].flags == 8'h00)
      rd(8'h08, rows[i].flags);
      rd(8'h08, 8'h00);
    end
    wb(1'b1, 8'h08, 8'hff, junk);
    rd(8'h08, 8'h00);
    rd(8'h0c, ID_EXP);
    rd(8'hfc, 8'h00);
    led_pwm_i <= 6'h2a;
    wb(1'b1, 8'h10, 8'h15, junk);
    tick(3);
    `CHK(led_out_o, 6'h3f)
    wb_sel_i <= 4'h0;
    wb(1'b1, 8'h10, 8'h00, junk);
    wb_sel_i <= 4'hf;
    rd(8'h10, 8'h15);
    wb(1'b1, 8'h10, 8'h00, junk);
    tick(3);
    `CHK(led_out_o, 6'h2a)
    {overcurrent_i, boost_low_i} <= 2'h3;
    tick(12);
    `CHK(boost_en_o, 1'b1)
    tick(20);
    `CHK(boost_en_o, 1'b0)
    {overcurrent_i, boost_low_i} <= 2'h0;
    tick(4);
    `CHK(boost_en_o, 1'b0)
    rd(8'h08, 8'h04);
    tick(4);
    `CHK(boost_en_o, 1'b1)
    over_temp_i <= 1'b1;
    tick(6);
    over_temp_i <= 1'b0;
    tick(6);
    `CHK(led_en_o, 1'b0)
    temp_recovered_i <= 1'b1;
    tick(6);
    `CHK(led_en_o, 1'b1)
    temp_recovered_i <= 1'b0;
    rd(8'h08, 8'h02);
    rd(8'h24, 8'h3e);
    for (int m = 1; m >= 0; m--) begin
      wb(1'b1, 8'h20, m[7:0], junk);
      supply_input_mv_i <= 16'h1387;
      tick(6);
      `CHK({led_en_o, irq_o}, {1'b0, m[0]})
      supply_input_mv_i <= 16'h1388;
      tick(6);
      `CHK(boost_en_o, 1'b1)
      rd(8'h24, 8'h01);
      rd(8'h08, 8'h01);
      tick(2);
      `CHK(irq_o, 1'b0)
    end
    chan_fault_i <= 6'h01;
    tick(6);
    {chan_fault_i, enable_pin_i} <= 7'h00;
    tick(6);
    enable_pin_i <= 1'b1;
    tick(6);
    `CHK(fault_pin_oe_n_o, 1'b1)
    rd(8'h08, 8'h00);
    wb(1'b1, 8'h10, 8'h3f, junk);
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(2);
    rd(8'h10, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
